// ===== src/dssr_pkg.sv
// Purpose : Constants for the DMA and SCSI status register bank
// Assumes : Byte-wide register reads at the printed offsets
// Notes   : Shared by the bank and its bench
package dssr_pkg;
   localparam logic [7:0] DMA_EVENT_STATUS_OFS = 8'h0c;
   localparam logic [7:0] SCSI_STATUS_ZERO_OFS = 8'h0d;
   localparam logic [7:0] SCSI_STATUS_ONE_OFS  = 8'h0e;
   localparam logic [7:0] SCSI_STATUS_TWO_OFS  = 8'h0f;
   // Event status field positions
   localparam int FIFO_EMPTY_BIT   = 7;
   localparam int MASTER_PAR_BIT   = 6;
   localparam int BUS_FAULT_BIT    = 5;
   localparam int ABORT_DONE_BIT   = 4;
   localparam int SINGLE_STEP_BIT  = 3;
   localparam int SCRIPT_IRQ_BIT   = 2;
   localparam int ILLEGAL_BIT      = 0;
   localparam int PARITY_ENA_BIT   = 3;
   // Reset values
   localparam logic [7:0] DMA_EVENT_RESET = 8'h80;
   localparam logic [7:0] STATUS_RESET    = 8'h00;
   // Host spacing between consecutive status reads
   localparam int READ_GAP_CYCLES  = 12;
   localparam logic [4:0] FIFO_MAX_COUNT = 5'h10;
endpackage

// ===== src/dssr_status_regs.sv
// Purpose : Read-only DMA event and SCSI status registers
// Assumes : One core clock; SCSI lines arrive asynchronously
// Notes   : Event inputs are one-cycle pulses from the engine
// How it works
// R1 - Reading event status clears set bits and the pending flag; new events still land
// R2 - Each interrupt condition is gated by its own enable mask bit
// R3 - Host waits twelve core clocks between consecutive status reads
// R4 - Bit 7 follows FIFO empty, resets to one, never interrupts
// R5 - Bit 6 sets on master parity error, only when test register enable set
// R6 - Bit 5 sets when a master cycle ends in bad address or target abort
// R7 - Bit 4 sets when a software requested abort completes
// R8 - Bit 3 sets after each successful instruction while single-step enabled
// R9 - Bit 2 sets when an interrupt instruction condition is true
// R10 - Bit 0 sets on illegal opcode or REQ during wait-disconnect
// R11 - Illegal flag sets on block move with zero byte count
// R12 - Transfer control illegal for bad compare, carry, reserved or wait-phase use
// R13 - Load/store illegal for register map, alignment, command, count or dword cross
// R14 - Memory move illegal for reserved command bits or mismatched alignment
// R15 - Status zero bits 7..5 show input latch, hidden buffer, output latch full
// R16 - Async receive uses input latch; sync send uses output latch then hidden buffer
// R17 - Bit 4 shows arbitration in progress; bit 3 shows arbitration lost
// R18 - Bit 2 sets on won arbitration only in full arbitration mode
// R19 - Bit 1 shows live reset or software reset; bit 0 live parity line
// R20 - Five-bit live synchronous FIFO count, 0 to 16, split across registers
// R21 - Status one bit 3 holds parity of the latched input byte
// R22 - Status one bits 2..0 capture phase lines on each REQ assertion
`timescale 1ns/1ps
`default_nettype none
module dssr_status_regs
(
   input  wire  logic       clk_sys_i,
   input  wire  logic       rstn_i,
   input  wire  logic       soft_rst_i,         // Software reset control level
   input  wire  logic       rd_i,               // One-cycle register read strobe
   input  wire  logic [7:0] addr_i,
   output var   logic [7:0] rdata_o,
   output var   logic       dma_irq_pending_o,
   output var   logic       dma_irq_o,
   input  wire  logic [7:0] dma_irq_enable_reg_i,
   input  wire  logic       single_step_ena_i,  // From dma_control_reg
   input  wire  logic       parity_err_ena_i,   // test_register_four bit 3
   input  wire  logic       full_arb_mode_i,    // From scsi_control_zero
   input  wire  logic       dma_fifo_empty_i,
   input  wire  logic       master_parity_err_i,
   input  wire  logic       target_parity_err_i,
   input  wire  logic       bad_address_i,
   input  wire  logic       target_abort_i,
   input  wire  logic       abort_done_i,
   input  wire  logic       instr_done_i,
   input  wire  logic       script_irq_true_i,
   input  wire  logic       illegal_opcode_i,
   input  wire  logic       wait_disc_i,        // Wait-disconnect executing
   input  wire  logic       block_move_i,
   input  wire  logic       xfer_ctl_i,
   input  wire  logic       load_store_i,
   input  wire  logic       mem_move_i,
   input  wire  logic       target_mode_i,
   input  wire  logic       ls_reg_space_i,     // Load/store address hits registers
   input  wire  logic       mm_reserved_i,      // Memory move reserved bits set
   input  wire  logic [23:0] byte_counter_reg_i,
   input  wire  logic [7:0] command_reg_i,
   input  wire  logic [1:0] reg_addr_lsb_i,
   input  wire  logic [1:0] mem_addr_lsb_i,
   input  wire  logic [1:0] src_addr_lsb_i,
   input  wire  logic [1:0] dst_addr_lsb_i,
   input  wire  logic       sync_mode_i,
   input  wire  logic       rx_byte_i,          // Async byte arrives in input latch
   input  wire  logic       rx_take_i,          // Input latch drained to DMA FIFO
   input  wire  logic       tx_load_i,          // DMA writes output latch
   input  wire  logic       tx_send_i,          // Byte leaves toward the bus
   input  wire  logic [4:0] fifo_fill_count_i,
   input  wire  logic       bus_free_i,
   input  wire  logic       own_id_bsy_i,
   input  wire  logic       won_i,
   input  wire  logic       scsi_rst_i,         // SCSI bus pins, asynchronous
   input  wire  logic       low_byte_parity_line_i,
   input  wire  logic       scsi_sel_i,
   input  wire  logic       scsi_req_i,
   input  wire  logic       scsi_msg_i,
   input  wire  logic       scsi_cd_i,
   input  wire  logic       scsi_io_i
);
   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   localparam int NPIN = 7;
   logic [NPIN-1:0] pin_raw;
   wire  [NPIN-1:0] pin_r;      // Filtered pin levels, one flop per bit
   assign pin_raw = {scsi_rst_i, low_byte_parity_line_i, scsi_sel_i, scsi_req_i,
                     scsi_msg_i, scsi_cd_i, scsi_io_i};
   // A change counts only once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_sync
         logic s1_r;              // Flops stay local so no vector has two writers
         logic s2_r;
         logic s3_r;
         logic hold_r;
         always_ff @(posedge clk_sys_i)
         begin
            if (!rstn_i)
            begin
               s1_r   <= 1'b0;
               s2_r   <= 1'b0;
               s3_r   <= 1'b0;
               hold_r <= 1'b0;
            end
            else
            begin
               s1_r <= pin_raw[gi];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r)
                  hold_r <= s3_r;
            end
         end
         assign pin_r[gi] = hold_r;
      end
   endgenerate
   wire rst_s  = pin_r[6];
   wire par_s  = pin_r[5];
   wire sel_s  = pin_r[4];
   wire req_s  = pin_r[3];
   logic req_d_r;
   wire  req_rise = req_s & ~req_d_r;

   // Edge memory shares the pin filter's reset, so a soft reset cannot fake a REQ edge
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
         req_d_r <= 1'b0;
      else
         req_d_r <= req_s;
   end

   // ***************************************************************
   // Illegal instruction decode
   // ***************************************************************
   wire [23:0] bc = byte_counter_reg_i;
   wire ill_wait   = wait_disc_i & req_rise;                           // R10
   wire ill_bm     = block_move_i & (bc == 24'h000000);                // R11
   wire ill_tc     = xfer_ctl_i & ((target_mode_i & (bc[18] | bc[17] | bc[16]))
                     | (bc[21] & (bc[18] | bc[17])) | bc[22]);         // R12
   wire [2:0] ls_cnt = bc[2:0];
   wire ill_ls     = load_store_i & (ls_reg_space_i
                     | (reg_addr_lsb_i != mem_addr_lsb_i)
                     | ~command_reg_i[5] | command_reg_i[3] | command_reg_i[2]
                     | (ls_cnt == 3'h0) | (ls_cnt > 3'h4)
                     | (({2'b00, mem_addr_lsb_i} + {1'b0, ls_cnt}) > 4'h4)); // R13
   wire ill_mm     = mem_move_i & (mm_reserved_i
                     | (src_addr_lsb_i != dst_addr_lsb_i));            // R14
   wire illegal_ev = illegal_opcode_i | ill_wait | ill_bm | ill_tc | ill_ls | ill_mm; // R10

   // ***************************************************************
   // DMA event status
   // ***************************************************************
   logic [7:0] evt_r;
   logic [7:0] evt_set;
   logic [7:0] evt_nxt;
   wire rd_evt = rd_i & (addr_i == dssr_pkg::DMA_EVENT_STATUS_OFS);
   assign evt_set[dssr_pkg::FIFO_EMPTY_BIT]  = 1'b0;
   assign evt_set[dssr_pkg::MASTER_PAR_BIT]  = parity_err_ena_i
          & (master_parity_err_i | target_parity_err_i);               // R5
   assign evt_set[dssr_pkg::BUS_FAULT_BIT]   = bad_address_i | target_abort_i; // R6
   assign evt_set[dssr_pkg::ABORT_DONE_BIT]  = abort_done_i;           // R7
   assign evt_set[dssr_pkg::SINGLE_STEP_BIT] = single_step_ena_i & instr_done_i; // R8
   assign evt_set[dssr_pkg::SCRIPT_IRQ_BIT]  = script_irq_true_i;      // R9
   assign evt_set[1] = 1'b0;
   assign evt_set[dssr_pkg::ILLEGAL_BIT]     = illegal_ev;
   // Set wins over the read clear, so a stacked event is never dropped
   assign evt_nxt = ((rd_evt ? 8'h00 : evt_r) | evt_set) & 8'h7d;      // R1
   wire [7:0] evt_view = {dma_fifo_empty_i, evt_r[6:0]};               // R4
   wire irq_nxt = |(evt_nxt & dma_irq_enable_reg_i & 8'h7d);           // R2

   // ***************************************************************
   // Data latch occupancy
   // ***************************************************************
   logic il_full_r;
   logic ob_full_r;
   logic ol_full_r;
   logic lat_par_r;
   logic [2:0] phase_r;
   wire rx_load = rx_byte_i & ~sync_mode_i;                            // R16
   wire ol_move = tx_send_i & ol_full_r & sync_mode_i & ~ob_full_r;    // R16

   // ***************************************************************
   // Arbitration status
   // ***************************************************************
   logic aip_r;
   logic loa_r;
   logic woa_r;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || soft_rst_i)
      begin
         evt_r             <= 8'h00;
         dma_irq_pending_o <= 1'b0;
         dma_irq_o         <= 1'b0;
         il_full_r         <= 1'b0;
         ob_full_r         <= 1'b0;
         ol_full_r         <= 1'b0;
         lat_par_r         <= 1'b0;
         phase_r           <= 3'h0;
         aip_r             <= 1'b0;
         loa_r             <= 1'b0;
         woa_r             <= 1'b0;
      end
      else
      begin
         evt_r             <= evt_nxt;
         dma_irq_pending_o <= irq_nxt;                                 // R1
         dma_irq_o         <= irq_nxt;                                 // R2
         if (req_rise)
            phase_r <= pin_r[2:0];                                     // R22
         if (rx_load)
         begin
            il_full_r <= 1'b1;                                         // R15
            lat_par_r <= par_s;                                        // R21
         end
         else if (rx_take_i)
            il_full_r <= 1'b0;
         // Output path: async bytes leave the output latch directly
         if (tx_load_i)
            ol_full_r <= 1'b1;                                         // R15
         else if (ol_move || (tx_send_i && !sync_mode_i))
            ol_full_r <= 1'b0;
         if (ol_move)
            ob_full_r <= 1'b1;
         else if (tx_send_i && sync_mode_i)
            ob_full_r <= 1'b0;
         aip_r <= bus_free_i & own_id_bsy_i;                           // R17
         if (aip_r && sel_s && !won_i)
            loa_r <= 1'b1;                                             // R17
         else if (bus_free_i && !own_id_bsy_i)
            loa_r <= 1'b0;
         if (aip_r && won_i && full_arb_mode_i)
            woa_r <= 1'b1;                                             // R18
         else if (bus_free_i && !own_id_bsy_i)
            woa_r <= 1'b0;
      end
   end

   // ***************************************************************
   // Read mux
   // ***************************************************************
   wire [4:0] ffc = (fifo_fill_count_i > dssr_pkg::FIFO_MAX_COUNT)
                    ? dssr_pkg::FIFO_MAX_COUNT : fifo_fill_count_i;    // R20
   wire [7:0] st0 = {il_full_r, ob_full_r, ol_full_r, aip_r, loa_r, woa_r,
                     rst_s | soft_rst_i, par_s};                       // R19
   wire [7:0] st1 = {ffc[3:0], lat_par_r, phase_r};
   wire [7:0] st2 = {3'h0, ffc[4], 4'h0};
   wire [7:0] rd_mux = (addr_i == dssr_pkg::DMA_EVENT_STATUS_OFS) ? evt_view :
                       (addr_i == dssr_pkg::SCSI_STATUS_ZERO_OFS) ? st0 :
                       (addr_i == dssr_pkg::SCSI_STATUS_ONE_OFS)  ? st1 :
                       (addr_i == dssr_pkg::SCSI_STATUS_TWO_OFS)  ? st2 : 8'h00;
   // Registered read data keeps the output straight from a flop
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
         rdata_o <= dssr_pkg::STATUS_RESET;
      else if (rd_i)
         rdata_o <= rd_mux;
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   rd_clear_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R1
      rd_evt && !soft_rst_i |=> (evt_r & ~$past(evt_set)) == 8'h00)
      else $error("Event bits survived a read");
   mask_gate_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R2
      dma_irq_o |-> |($past(evt_nxt) & $past(dma_irq_enable_reg_i)))
      else $error("Interrupt raised by masked event");
   empty_view_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R4
      rd_evt |=> rdata_o[7] == $past(dma_fifo_empty_i))
      else $error("Empty bit does not follow FIFO");
   par_gate_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R5
      !parity_err_ena_i && !evt_r[6] && !soft_rst_i |=> !evt_r[6])
      else $error("Parity bit set while disabled");
   step_set_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R8
      single_step_ena_i && instr_done_i && !soft_rst_i |=> evt_r[3])
      else $error("Single step bit missed");
   zero_cnt_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R11
      block_move_i && bc == 24'h0 && !soft_rst_i |=> evt_r[0])
      else $error("Zero count not flagged");
   won_mode_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R18
      !full_arb_mode_i && !woa_r |=> !woa_r)
      else $error("Won set outside full arbitration");
   phase_cap_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R22
      req_rise && !soft_rst_i |=> phase_r == $past(pin_r[2:0]))
      else $error("Phase lines not captured on REQ");
   fault_set_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R6
      (bad_address_i || target_abort_i) && !soft_rst_i |=> evt_r[5])
      else $error("Bus fault not flagged");
   abort_set_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R7
      abort_done_i && !soft_rst_i |=> evt_r[4])
      else $error("Abort completion not flagged");
   pend_clear_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R1
      rd_evt && !(|(evt_set & dma_irq_enable_reg_i & 8'h7d)) |=> !dma_irq_pending_o)
      else $error("Pending flag survived a quiet read");
   rst_live_a : assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R19
      rd_i && addr_i == dssr_pkg::SCSI_STATUS_ZERO_OFS && soft_rst_i |=> rdata_o[1])
      else $error("Software reset missing from status zero");
endmodule
`default_nettype wire

// ===== verif/dssr_host_model.sv
// Purpose : Host reader model for the status register bank
// Assumes : A read is a one-cycle strobe taken at a rising edge
// Notes   : Holds the idle gap that clear-on-read needs
`timescale 1ns/1ps
`default_nettype none
module dssr_host_model
(
   input  wire logic       clk_sys_i,
   output var  logic       rd_o,
   output var  logic [7:0] addr_o
);
   int unsigned idle_cnt = 0;

   // Idle clocks since the last strobe
   always @(posedge clk_sys_i)
      idle_cnt <= rd_o ? 0 : idle_cnt + 1;

   // One read; a released address shows its inverse, never a stale offset
   task automatic do_read(input logic [7:0] a);
      @(negedge clk_sys_i);
      while (idle_cnt < dssr_pkg::READ_GAP_CYCLES)
         @(negedge clk_sys_i);
      rd_o   = 1'b1;
      addr_o = a;
      @(negedge clk_sys_i);
      rd_o   = 1'b0;
      addr_o = ~a;
   endtask

   initial
   begin
      rd_o   = 1'b0;
      addr_o = 8'h00;
   end
endmodule
`default_nettype wire

// ===== verif/dssr_status_regs_bench.sv
// Purpose : Self-checking bench for the status register bank
// Assumes : Host model spaces reads; results come back in order
// Notes   : Each note carries a mask for bits left open
`timescale 1ns/1ps
`default_nettype none
module dssr_status_regs_bench;
   logic clk_sys_i, rstn_i, soft_rst_i, rd_i, single_step_ena_i, parity_err_ena_i;
   logic full_arb_mode_i, dma_fifo_empty_i, master_parity_err_i, target_parity_err_i;
   logic bad_address_i, target_abort_i, abort_done_i, instr_done_i, script_irq_true_i;
   logic illegal_opcode_i, wait_disc_i, block_move_i, xfer_ctl_i, load_store_i;
   logic mem_move_i, target_mode_i, ls_reg_space_i, mm_reserved_i, sync_mode_i;
   logic rx_byte_i, rx_take_i, tx_load_i, tx_send_i, bus_free_i, own_id_bsy_i, won_i;
   logic scsi_rst_i, low_byte_parity_line_i, scsi_sel_i, scsi_req_i, scsi_msg_i;
   logic scsi_cd_i, scsi_io_i, dma_irq_pending_o, dma_irq_o;
   logic [7:0]  addr_i, rdata_o, dma_irq_enable_reg_i, command_reg_i, e, m;
   logic [23:0] byte_counter_reg_i;
   logic [1:0]  reg_addr_lsb_i, mem_addr_lsb_i, src_addr_lsb_i, dst_addr_lsb_i;
   logic [4:0]  fifo_fill_count_i, c;
   logic [2:0]  ph;
   logic [15:0] q[$];
   int          err_total, n_tests;
   int          eb[16] = '{6, 6, 5, 5, 4, 3, 2, 0, 0, 0, 0, 0, 8, 8, 8, 8};
   int          lk[5] = '{16, 17, 16, 18, 19};
   logic [7:0]  lx[5] = '{8'h80, 8'h00, 8'h00, 8'h20, 8'h40};
   logic [23:0] tc[5] = '{24'h040000, 24'h020000, 24'h010000, 24'h240000, 24'h400000};
   int          v = 0;
   localparam logic [7:0] EV = dssr_pkg::DMA_EVENT_STATUS_OFS;
   localparam logic [7:0] S0 = dssr_pkg::SCSI_STATUS_ZERO_OFS;
   localparam logic [7:0] S1 = dssr_pkg::SCSI_STATUS_ONE_OFS;

   dssr_status_regs u_dut (.*);
   dssr_host_model  u_host (.clk_sys_i(clk_sys_i), .rd_o(rd_i), .addr_o(addr_i));

   always #5 clk_sys_i = ~clk_sys_i;

   // ****************************************
   // Checks and drivers
   // ****************************************
   task automatic chk_data(input logic [7:0] g, input logic [7:0] x);
      n_tests++;
      if (g !== x)
      begin
         err_total++;
         $display("MISMATCH %0t data %h exp %h", $time, g, x);
      end
   endtask

   task automatic chk_irq(input logic [1:0] g, input logic [1:0] x);
      n_tests++;
      if (g !== x)
      begin
         err_total++;
         $display("MISMATCH %0t irq %b exp %b", $time, g, x);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] k);
      q.push_back({k, x});
      u_host.do_read(a);
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   task automatic clr();
      {master_parity_err_i, target_parity_err_i, bad_address_i, target_abort_i,
       abort_done_i, instr_done_i, script_irq_true_i, illegal_opcode_i, block_move_i,
       xfer_ctl_i, load_store_i, mem_move_i, rx_byte_i, rx_take_i, tx_load_i,
       tx_send_i} = 16'h0000;
   endtask

   // One-cycle strobe; context makes only the chosen case illegal
   task automatic hit(input int k);
      logic [1:0] r;
      r = 2'($urandom_range(3, 0));
      @(negedge clk_sys_i);
      {reg_addr_lsb_i, mem_addr_lsb_i, src_addr_lsb_i, dst_addr_lsb_i} = {4{r}};
      byte_counter_reg_i = (k == 8) ? 24'h0 : 24'(3'h4 - r);
      target_mode_i = (k == 9) && (v < 3);
      command_reg_i = 8'h20;
      ls_reg_space_i = 1'b0;
      mm_reserved_i = (k == 11) && !v[0];
      parity_err_ena_i = (k != 12);
      single_step_ena_i = (k != 13);
      // Pass number v picks which illegal variant cases 9 to 11 exercise
      if (k == 9)
         byte_counter_reg_i = tc[v];
      if (k == 10)
         case (v)
            0:       command_reg_i = 8'h00;
            1:       ls_reg_space_i = 1'b1;
            2:       reg_addr_lsb_i = ~r;
            3:       byte_counter_reg_i = 24'h0;
            default: byte_counter_reg_i = 24'(3'h5 - r);
         endcase
      if (k == 11 && v[0])
         dst_addr_lsb_i = ~r;
      case (k)
         0, 12:   master_parity_err_i = 1'b1;
         1:       target_parity_err_i = 1'b1;
         2:       bad_address_i = 1'b1;
         3:       target_abort_i = 1'b1;
         4:       abort_done_i = 1'b1;
         5, 13:   instr_done_i = 1'b1;
         6:       script_irq_true_i = 1'b1;
         7:       illegal_opcode_i = 1'b1;
         8, 14:   block_move_i = 1'b1;
         9:       xfer_ctl_i = 1'b1;
         10, 15:  load_store_i = 1'b1;
         11:      mem_move_i = 1'b1;
         16:      rx_byte_i = 1'b1;
         17:      rx_take_i = 1'b1;
         18:      tx_load_i = 1'b1;
         default: tx_send_i = 1'b1;
      endcase
      @(negedge clk_sys_i);
      clr();
   endtask

   task automatic end_of_test();
      if (q.size() != 0)
         err_total++;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Read data is settled two falling edges after the strobe is taken
   initial
   forever
   begin
      @(posedge clk_sys_i);
      if (rd_i === 1'b1)
      begin
         wt(2);
         chk_data(rdata_o & q[0][15:8], q[0][7:0] & q[0][15:8]);
         void'(q.pop_front());
      end
   end

   // Run needs under 5k cycles; a hang is cut well beyond that
   initial
   begin
      #200us;
      err_total++;
      end_of_test();
   end

   initial
   begin
      {clk_sys_i, rstn_i, err_total, n_tests} = '0;
      clr();
      {soft_rst_i, full_arb_mode_i, wait_disc_i, target_mode_i, ls_reg_space_i,
       mm_reserved_i, sync_mode_i, bus_free_i, own_id_bsy_i, won_i, scsi_rst_i,
       low_byte_parity_line_i, scsi_sel_i, scsi_req_i, scsi_msg_i, scsi_cd_i,
       scsi_io_i} = 17'h00000;
      {single_step_ena_i, parity_err_ena_i, dma_fifo_empty_i} = 3'h7;
      {dma_irq_enable_reg_i, command_reg_i, byte_counter_reg_i} = 40'h0;
      {reg_addr_lsb_i, mem_addr_lsb_i, src_addr_lsb_i, dst_addr_lsb_i} = 8'h00;
      fifo_fill_count_i = 5'h00;
      void'($urandom(32'hfbe0));
      wt(10);
      rstn_i = 1'b1;
      rd(EV, dssr_pkg::DMA_EVENT_RESET, 8'hff);
      rd(S0, dssr_pkg::STATUS_RESET, 8'hff);
      rd(8'h10, 8'h00, 8'hff);
      dma_fifo_empty_i = 1'b0;
      rd(EV, 8'h00, 8'h80);
      dma_fifo_empty_i = 1'b1;
      // Every cause but REQ during wait-disconnect, with random masks; bit 7 must never interrupt
      for (int p = 0; p < 5; p++)
      begin
         v = p;
         for (int k = 0; k < 16; k++)
         begin
            m = 8'($urandom);
            dma_irq_enable_reg_i = m;
            e = (eb[k] < 8) ? 8'h01 << eb[k] : 8'h00;
            hit(k);
            wt(3);
            chk_irq({dma_irq_o, dma_irq_pending_o}, {2{|(e & m & 8'h7d)}});
            rd(EV, 8'h80 | e, 8'hff);
            rd(EV, 8'h80, 8'hff);
            wt(2);
            chk_irq({dma_irq_o, dma_irq_pending_o}, 2'b00);
         end
      end
      // An event landing on the clearing read must survive it
      fork
         rd(EV, 8'h80, 8'hff);
         begin
            wait (rd_i === 1'b1);
            script_irq_true_i = 1'b1;
            wt(1);
            script_irq_true_i = 1'b0;
         end
      join
      rd(EV, 8'h84, 8'hff);
      {wait_disc_i, scsi_req_i} = 2'b11;
      wt(8);
      {wait_disc_i, scsi_req_i} = 2'b00;
      rd(EV, 8'h81, 8'hff);
      for (int i = 0; i < 5; i++)
      begin
         sync_mode_i = (i > 1);
         hit(lk[i]);
         rd(S0, lx[i], 8'he0);
      end
      {bus_free_i, own_id_bsy_i, sync_mode_i} = 3'b110;
      wt(3);
      rd(S0, 8'h10, 8'h10);
      scsi_sel_i = 1'b1;
      wt(8);
      rd(S0, 8'h08, 8'h08);
      {scsi_sel_i, won_i} = 2'b01;
      wt(3);
      rd(S0, 8'h00, 8'h04);
      {full_arb_mode_i, won_i} = 2'b10;
      wt(2);
      won_i = 1'b1;
      wt(3);
      rd(S0, 8'h04, 8'h04);
      {bus_free_i, own_id_bsy_i, won_i, scsi_rst_i, low_byte_parity_line_i} = 5'h03;
      wt(8);
      rd(S0, 8'h03, 8'h03);
      hit(17);
      hit(16);
      {scsi_rst_i, low_byte_parity_line_i} = 2'b00;
      wt(8);
      rd(S0, 8'h00, 8'h03);
      rd(S1, 8'h08, 8'h08);
      // Software reset shows in status zero and wipes latched events
      hit(6);
      soft_rst_i = 1'b1;
      wt(2);
      chk_irq({dma_irq_o, dma_irq_pending_o}, 2'b00);
      rd(S0, 8'h02, 8'h02);
      rd(EV, 8'h80, 8'hff);
      soft_rst_i = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         c = (i == 0) ? 5'h10 : 5'($urandom_range(16, 0));
         ph = 3'($urandom);
         fifo_fill_count_i = c;
         {scsi_msg_i, scsi_cd_i, scsi_io_i, scsi_req_i} = {ph, 1'b1};
         wt(8);
         {scsi_msg_i, scsi_cd_i, scsi_io_i} = ~ph;
         wt(8);
         rd(S1, {c[3:0], 1'b0, ph}, 8'hf7);
         rd(dssr_pkg::SCSI_STATUS_TWO_OFS, {3'h0, c[4], 4'h0}, 8'hff);
         scsi_req_i = 1'b0;
         wt(8);
      end
      wt(20);
      end_of_test();
   end
endmodule
`default_nettype wire
